// ---- logic/lmon_pkg.sv ----
// Package: constants, layouts and types of the two-channel linkage monitor
package lmon_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned SIMUL_WINDOW_US = 500000;
  localparam int unsigned SIMUL_CYC = SIMUL_WINDOW_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned LINK_EXTRA_MS = 20;
  localparam int unsigned LINK_EXTRA_CYC = LINK_EXTRA_MS * 1000000 / CLK_PERIOD_NS;
  localparam int unsigned DELAY_EXTRA_MS = 40;
  localparam int unsigned DELAY_EXTRA_CYC = DELAY_EXTRA_MS * 1000000 / CLK_PERIOD_NS;
  localparam int unsigned SIMUL_CNT_W = 26;

  // ---------------------------------------------------------------
  // Register port
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_DELAY = 8'h04;
  localparam logic [7:0] OFS_SIGMAP = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_MASK = 8'h10;
  localparam logic [7:0] OFS_STATE = 8'h14;

  // Control fields
  localparam int unsigned CTRL_W = 5;
  localparam int unsigned CTRL_LINK_EN = 0;
  localparam int unsigned CTRL_ELECTRONIC = 1;
  localparam int unsigned CTRL_TWO_FUNC = 2;
  localparam int unsigned CTRL_LINK_TO_B = 3;
  localparam int unsigned CTRL_DELAY_EN = 4;
  localparam logic [4:0] CTRL_RST = 5'h00;
  localparam logic [31:0] DELAY_RST = 32'h0000_0000;

  // Indication mapping: four outputs, three select bits each
  localparam int unsigned IND_N = 4;
  localparam int unsigned SEL_W = 3;
  localparam int unsigned SIGMAP_W = IND_N * SEL_W;
  localparam logic [11:0] SIGMAP_RST = 12'hFAC;
  localparam int unsigned SRC_PF_A = 0;
  localparam int unsigned SRC_PF_B = 1;
  localparam int unsigned SRC_WF = 2;
  localparam int unsigned SRC_FP_CHG = 3;
  localparam int unsigned SRC_DEV = 4;
  localparam int unsigned SRC_ERR = 5;
  localparam int unsigned SRC_WARN = 6;
  localparam int unsigned SRC_DIAG = 7;

  // Status / mask bits
  localparam int unsigned EV_W = 4;
  localparam int unsigned EV_LINK_OPEN = 0;
  localparam int unsigned EV_SIMUL_FAULT = 1;
  localparam int unsigned EV_A_OFF = 2;
  localparam int unsigned EV_B_OFF = 3;
  localparam logic [3:0] EV_RST = 4'h0;

  // State readback bits
  localparam int unsigned ST_OUT_A = 0;
  localparam int unsigned ST_OUT_B = 1;
  localparam int unsigned ST_CLOSED_OK = 2;
  localparam int unsigned ST_FAULT = 3;
  localparam int unsigned ST_CHAN_A = 4;
  localparam int unsigned ST_CHAN_B = 5;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic a;
    logic b;
  } lmon_chan_t;

  typedef struct packed {
    logic wf_viol;
    logic fp_change;
    logic dev_func;
    logic err;
    logic warn;
    logic diag;
  } lmon_sig_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } lmon_req_t;

  typedef enum logic [3:0] {
    SM_OPEN = 4'h1,
    SM_WAIT = 4'h2,
    SM_CLOSED = 4'h4,
    SM_FAULT = 4'h8
  } lmon_sm_t;

  typedef struct packed {
    lmon_sm_t sm;
    logic [SIMUL_CNT_W-1:0] cnt;
    logic ok;
    logic flt;
    logic flt_p;
  } lmon_simul_st_t;

  typedef struct packed {
    logic [CTRL_W-1:0] ctrl;
    logic [DATA_W-1:0] delay;
    logic [SIGMAP_W-1:0] sigmap;
    logic [EV_W-1:0] sts;
    logic [EV_W-1:0] mask;
    logic [DATA_W-1:0] dcnt;
    logic out_a;
    logic out_b;
    logic [IND_N-1:0] ind;
    logic irq;
    logic [DATA_W-1:0] rdata;
    logic prev_ok;
  } lmon_top_st_t;

endpackage

// ---- logic/lmon_simul.sv ----
// Simultaneity check of the two upstream linkage channels
`timescale 1ns/1ps
module lmon_simul #(
  parameter int unsigned WINDOW_CYC = lmon_pkg::SIMUL_CYC
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  input wire lmon_pkg::lmon_chan_t chan_i,
  output logic closed_ok_o,
  output logic fault_o,
  output logic fault_pulse_o
);
  import lmon_pkg::*;

  localparam logic [SIMUL_CNT_W-1:0] WIN_M1 = SIMUL_CNT_W'(WINDOW_CYC - 1);

  lmon_simul_st_t st_reg;
  lmon_simul_st_t st_next;
  logic both_closed;
  logic both_open;

  assign both_closed = chan_i.a && chan_i.b;
  assign both_open = !chan_i.a && !chan_i.b;

  always_comb begin
    st_next = st_reg;
    st_next.flt_p = 1'b0;
    unique case (st_reg.sm)
      SM_OPEN: begin
        st_next.cnt = '0;
        if (both_closed) begin
          st_next.sm = SM_CLOSED;
        end else if (!both_open) begin
          st_next.sm = SM_WAIT;
        end
      end
      SM_WAIT: begin
        // Second channel must follow within the window
        if (both_closed) begin
          st_next.sm = SM_CLOSED;
        end else if (both_open) begin
          st_next.sm = SM_OPEN;
        end else if (st_reg.cnt == WIN_M1) begin
          st_next.sm = SM_FAULT;
          st_next.flt_p = 1'b1;
        end else begin
          st_next.cnt = st_reg.cnt + 1'b1;
        end
      end
      SM_CLOSED: begin
        if (!both_closed) begin
          st_next.sm = SM_OPEN;
        end
      end
      SM_FAULT: begin
        // Locked until both channels seen open again
        if (both_open) begin
          st_next.sm = SM_OPEN;
        end
      end
      default: begin
        st_next.sm = SM_FAULT;
      end
    endcase
    st_next.ok = (st_next.sm == SM_CLOSED);
    st_next.flt = (st_next.sm == SM_FAULT);
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      st_reg <= '{sm: SM_OPEN, cnt: '0, ok: 1'b0, flt: 1'b0, flt_p: 1'b0};
    end else if (ce_i) begin
      st_reg <= st_next;
    end
  end

  assign closed_ok_o = st_reg.ok;
  assign fault_o = st_reg.flt;
  assign fault_pulse_o = st_reg.flt_p;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);

  open_drops_ok_a: assert property (ce_i && !both_closed |=> !closed_ok_o)
    else $error("closed_ok stayed high with a channel open");
  fault_locks_a: assert property (fault_o && ce_i && !both_open |=> fault_o)
    else $error("fault left before both channels opened");
  fault_pulse_a: assert property (fault_pulse_o |-> fault_o && !closed_ok_o)
    else $error("fault pulse without fault state");
  ok_needs_closed_a: assert property (closed_ok_o |-> $past(both_closed))
    else $error("closed_ok without both channels closed");
endmodule

// ---- logic/lmon_top.sv ----
// Two-channel linkage monitor with output pair control and indication mapping
//
// Functional notes
// - With linkage on, an open upstream circuit forces off the output pair of its assigned function; in single function mode, both pairs.
// - Linkage adds no more than 20 ms to the switch-off response.
// - With the safe time delay, linkage adds no more than 40 ms to the delayed switch-off.
// - Contact linkage lets outputs on only with field free and both contacts closed within 0.5 s.
// - Electronic linkage lets outputs on only with field free and both upstream outputs on within 0.5 s.
// - Channels failing to close within the window raise a fault indication.
// - Linkage acts only when enabled; disabled, the channels have no effect.
// - Linkage acts only on the output pair of its assigned protective function.
// - Indications exist for field violations, changeover, device, error, warning and diagnosis.
// - The source routed to each indication output is set by configuration.
// - With two functions, each pair follows only its own field and violation.
// - In single function mode the second pair may switch off delayed after the first.
`timescale 1ns/1ps
module lmon_top #(
  parameter int unsigned WINDOW_CYC = lmon_pkg::SIMUL_CYC
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  input wire lmon_pkg::lmon_req_t req_i,
  input wire lmon_pkg::lmon_chan_t chan_i,
  input wire logic pf_free_a_i,
  input wire logic pf_free_b_i,
  input wire lmon_pkg::lmon_sig_t sig_i,
  output logic [lmon_pkg::DATA_W-1:0] rd_data_o,
  output logic out_pair_a_o,
  output logic second_output_pair_o,
  output logic [lmon_pkg::IND_N-1:0] ind_o,
  output logic link_fault_o,
  output logic irq_o
);
  import lmon_pkg::*;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic pick_src(input logic [SIGMAP_W-1:0] map, input int unsigned idx,
                                    input logic [7:0] src);
    logic [SEL_W-1:0] sel;
    sel = map[idx*SEL_W +: SEL_W];
    return src[sel];
  endfunction

  function automatic logic hit(input lmon_req_t r, input logic [7:0] ofs);
    return r.addr == ofs;
  endfunction

  // ---------------------------------------------------------------
  // Simultaneity checker
  // ---------------------------------------------------------------
  logic closed_ok;
  logic simul_fault;
  logic simul_fault_p;
  logic fault_reg;

  lmon_simul #(.WINDOW_CYC(WINDOW_CYC)) u_simul (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .ce_i(ce_i),
    .chan_i(chan_i),
    .closed_ok_o(closed_ok),
    .fault_o(simul_fault),
    .fault_pulse_o(simul_fault_p)
  );

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  lmon_top_st_t st_reg;
  lmon_top_st_t st_next;
  logic link_en;
  logic link_ok;
  logic two_func;
  logic delay_mode;
  logic want_a;
  logic want_b;
  logic a_on;
  logic [EV_W-1:0] ev;
  logic [EV_W-1:0] w1c;
  logic [7:0] src;
  logic [DATA_W-1:0] state_word;

  assign link_en = st_reg.ctrl[CTRL_LINK_EN];
  assign two_func = st_reg.ctrl[CTRL_TWO_FUNC];
  assign delay_mode = !two_func && st_reg.ctrl[CTRL_DELAY_EN];
  assign link_ok = !link_en || closed_ok;

  always_comb begin
    st_next = st_reg;
    want_a = pf_free_a_i;
    want_b = pf_free_b_i;
    a_on = 1'b0;
    ev = '0;
    w1c = '0;
    src = '0;
    state_word = '0;

    // Linkage routed to the assigned function only
    if (two_func && st_reg.ctrl[CTRL_LINK_TO_B]) begin
      want_b = pf_free_b_i && link_ok;
    end else begin
      want_a = pf_free_a_i && link_ok;
    end

    // Pair A; restart held off while a delayed switch-off runs
    a_on = want_a && !(delay_mode && st_reg.dcnt != '0);
    st_next.out_a = a_on;

    // Pair B
    if (two_func) begin
      st_next.out_b = want_b;
      st_next.dcnt = '0;
    end else if (delay_mode) begin
      if (st_reg.out_a && !a_on) begin
        st_next.dcnt = st_reg.delay;
      end else if (st_reg.dcnt != '0) begin
        st_next.dcnt = st_reg.dcnt - 1'b1;
      end
      st_next.out_b = a_on || (st_reg.out_b && st_next.dcnt != '0);
    end else begin
      st_next.out_b = a_on;
      st_next.dcnt = '0;
    end

    // Indication sources and mapping
    src[SRC_PF_A] = !pf_free_a_i;
    src[SRC_PF_B] = !pf_free_b_i;
    src[SRC_WF] = sig_i.wf_viol;
    src[SRC_FP_CHG] = sig_i.fp_change;
    src[SRC_DEV] = sig_i.dev_func;
    src[SRC_ERR] = sig_i.err || (link_en && simul_fault);
    src[SRC_WARN] = sig_i.warn;
    src[SRC_DIAG] = sig_i.diag;
    for (int i = 0; i < IND_N; i++) begin
      st_next.ind[i] = pick_src(st_reg.sigmap, i, src);
    end

    // Events
    st_next.prev_ok = link_ok;
    ev[EV_LINK_OPEN] = st_reg.prev_ok && !link_ok;
    ev[EV_SIMUL_FAULT] = link_en && simul_fault_p;
    ev[EV_A_OFF] = st_reg.out_a && !st_next.out_a;
    ev[EV_B_OFF] = st_reg.out_b && !st_next.out_b;

    // Register writes
    if (req_i.wr) begin
      if (hit(req_i, OFS_CTRL)) begin
        st_next.ctrl = req_i.wdata[CTRL_W-1:0];
      end
      if (hit(req_i, OFS_DELAY)) begin
        st_next.delay = req_i.wdata;
      end
      if (hit(req_i, OFS_SIGMAP)) begin
        st_next.sigmap = req_i.wdata[SIGMAP_W-1:0];
      end
      if (hit(req_i, OFS_STATUS)) begin
        w1c = req_i.wdata[EV_W-1:0];
      end
      if (hit(req_i, OFS_MASK)) begin
        st_next.mask = req_i.wdata[EV_W-1:0];
      end
    end
    // Set wins over clear
    st_next.sts = (st_reg.sts & ~w1c) | ev;
    st_next.irq = |(st_next.sts & st_next.mask);

    // Register reads
    state_word[ST_OUT_A] = st_reg.out_a;
    state_word[ST_OUT_B] = st_reg.out_b;
    state_word[ST_CLOSED_OK] = closed_ok;
    state_word[ST_FAULT] = simul_fault;
    state_word[ST_CHAN_A] = chan_i.a;
    state_word[ST_CHAN_B] = chan_i.b;
    st_next.rdata = '0;
    if (req_i.rd) begin
      unique case (req_i.addr)
        OFS_CTRL: st_next.rdata = DATA_W'(st_reg.ctrl);
        OFS_DELAY: st_next.rdata = st_reg.delay;
        OFS_SIGMAP: st_next.rdata = DATA_W'(st_reg.sigmap);
        OFS_STATUS: st_next.rdata = DATA_W'(st_reg.sts);
        OFS_MASK: st_next.rdata = DATA_W'(st_reg.mask);
        OFS_STATE: st_next.rdata = state_word;
        default: st_next.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      st_reg <= '{ctrl: CTRL_RST, delay: DELAY_RST, sigmap: SIGMAP_RST, sts: EV_RST, mask: EV_RST,
                  dcnt: '0, out_a: 1'b0, out_b: 1'b0, ind: '0, irq: 1'b0, rdata: '0, prev_ok: 1'b1};
      fault_reg <= 1'b0;
    end else if (ce_i) begin
      st_reg <= st_next;
      fault_reg <= link_en && simul_fault;
    end
  end

  assign rd_data_o = st_reg.rdata;
  assign out_pair_a_o = st_reg.out_a;
  assign second_output_pair_o = st_reg.out_b;
  assign ind_o = st_reg.ind;
  assign link_fault_o = fault_reg;
  assign irq_o = st_reg.irq;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);

  // Cycles pair B has stayed on after pair A went off
  logic [DATA_W-1:0] b_lag;
  always_ff @(posedge clk_i) begin
    if (!nrst_i || !ce_i || !delay_mode || out_pair_a_o || !second_output_pair_o) begin
      b_lag <= '0;
    end else begin
      b_lag <= b_lag + 1'b1;
    end
  end

  link_open_off_a: assert property (ce_i && link_en && !closed_ok &&
                                    !(two_func && st_reg.ctrl[CTRL_LINK_TO_B]) |=> !out_pair_a_o)
    else $error("pair A on while linkage circuit open");
  link_resp_a: assert property ($fell(closed_ok) && link_en && !two_func ##0 ce_i [*2]
                                |-> ##[0:1] !out_pair_a_o)
    else $error("pair A switch-off slower than allowed");
  delay_bound_a: assert property (b_lag <= st_reg.delay + 32'h0000_0001)
    else $error("delayed pair stayed on past its delay");
  on_needs_ok_a: assert property ($rose(out_pair_a_o) |-> $past(pf_free_a_i) &&
                                  (!$past(link_en) || $past(closed_ok) || $past(two_func)))
    else $error("pair A switched on without free field and closed channels");
  fault_flag_a: assert property (ce_i && link_en && simul_fault |=> link_fault_o)
    else $error("simultaneity fault not shown");
  link_off_free_a: assert property (ce_i && !link_en && !two_func && !delay_mode && pf_free_a_i
                                    |=> out_pair_a_o)
    else $error("disabled linkage still blocks pair A");
  func_split_a: assert property (ce_i && two_func && pf_free_b_i && !st_reg.ctrl[CTRL_LINK_TO_B]
                                 |=> second_output_pair_o)
    else $error("linkage of function A affected pair B");
  indic_map_a: assert property (ce_i && st_reg.sigmap[SEL_W-1:0] == 3'h2 &&
                                 $stable(st_reg.sigmap) |=> ind_o[0] == $past(sig_i.wf_viol))
    else $error("indication 0 does not follow its mapped source");
  pair_b_own_a: assert property (ce_i && two_func && !pf_free_b_i |=> !second_output_pair_o)
    else $error("pair B on with its field violated");
  status_sticky_a: assert property (ce_i && st_reg.sts[EV_SIMUL_FAULT] &&
                                    !(req_i.wr && req_i.addr == OFS_STATUS) |=> st_reg.sts[EV_SIMUL_FAULT])
    else $error("status bit lost without clear");
endmodule

// ---- verification/lmon_chain.sv ----
// Model of the upstream two-channel contact chain
`timescale 1ns/1ps
module lmon_chain (
  input wire logic clk_i,
  output lmon_pkg::lmon_chan_t chan_o
);
  import lmon_pkg::*;
  // ---------------------------------------------------------------
  // Contact control
  // ---------------------------------------------------------------
  initial begin
    chan_o = '0;
  end
  // Second contact follows the first after skew cycles
  task automatic close_pair(input int skew);
    @(posedge clk_i);
    chan_o.a <= 1'b1;
    repeat (skew) @(posedge clk_i);
    chan_o.b <= 1'b1;
  endtask
  // Faulty switch: one contact stays open
  task automatic close_one();
    @(posedge clk_i);
    chan_o.a <= 1'b1;
  endtask
  task automatic open_pair();
    @(posedge clk_i);
    chan_o <= '0;
  endtask
endmodule

// ---- verification/tb_top.sv ----
// Self-checking testbench of the two-channel linkage monitor
`timescale 1ns/1ps
module tb_top;
  import lmon_pkg::*;
  localparam int unsigned WIN = 16;
  logic clk_i, nrst_i, ce_i, pf_free_a_i, pf_free_b_i;
  logic out_pair_a_o, second_output_pair_o, link_fault_o, irq_o, rd_d;
  logic [DATA_W-1:0] rd_data_o;
  logic [IND_N-1:0] ind_o, exp_ind;
  logic [7:0] src;
  logic [11:0] map;
  lmon_req_t req_i;
  lmon_chan_t chan_i;
  lmon_sig_t sig_i;
  int err_total, n_tests;
  integer seed = 32'h1a5e;
  logic [31:0] rd_q[$];

  lmon_top #(.WINDOW_CYC(WIN)) dut_u (.clk_i(clk_i), .nrst_i(nrst_i), .ce_i(ce_i), .req_i(req_i),
    .chan_i(chan_i), .pf_free_a_i(pf_free_a_i), .pf_free_b_i(pf_free_b_i), .sig_i(sig_i),
    .rd_data_o(rd_data_o), .out_pair_a_o(out_pair_a_o), .second_output_pair_o(second_output_pair_o),
    .ind_o(ind_o), .link_fault_o(link_fault_o), .irq_o(irq_o));
  lmon_chain up_u (.clk_i(clk_i), .chan_o(chan_i));

  // ---------------------------------------------------------------
  // Clock, watchdog, read monitor
  // ---------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  initial begin
    repeat (5000) @(posedge clk_i);
    err_total++;
    wrap_up();
  end
  always @(posedge clk_i) begin
    rd_d <= req_i.rd;
  end
  // Oldest noted read result against the data stand
  always @(negedge clk_i) begin
    if (rd_d && rd_q.size() > 0) begin
      chk("rd_data_o", rd_q.pop_front(), rd_data_o);
    end
  end

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic bus(input logic [7:0] a, input logic [31:0] d, input logic w);
    @(posedge clk_i);
    req_i <= '{addr: a, wdata: d, wr: w, rd: !w};
    @(posedge clk_i);
    req_i.wr <= 1'b0;
    req_i.rd <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp);
    rd_q.push_back(exp);
    bus(a, 32'h0, 1'b0);
  endtask
  task automatic pairs(input logic ea, input logic eb);
    @(negedge clk_i);
    chk("out_pair_a_o", {31'h0, ea}, {31'h0, out_pair_a_o});
    chk("second_output_pair_o", {31'h0, eb}, {31'h0, second_output_pair_o});
  endtask
  task automatic flag(input string nm, input logic e, input logic g);
    @(negedge clk_i);
    chk(nm, {31'h0, e}, {31'h0, g});
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  initial begin
    nrst_i = 1'b0;
    ce_i = 1'b1;
    req_i = '0;
    pf_free_a_i = 1'b1;
    pf_free_b_i = 1'b1;
    sig_i = '0;
    rd_d = 1'b0;
    err_total = 0;
    n_tests = 0;
    cyc(12);
    nrst_i <= 1'b1;
    rd_reg(OFS_CTRL, {27'h0, CTRL_RST});
    rd_reg(OFS_DELAY, DELAY_RST);
    rd_reg(OFS_SIGMAP, {20'h0, SIGMAP_RST});
    rd_reg(OFS_STATUS, 32'h0);
    rd_reg(OFS_MASK, 32'h0);
    bus(8'h18, 32'($random(seed)), 1'b1);
    rd_reg(8'h18, 32'h0);
    // Open chain ignored while linkage is off
    cyc(3);
    pairs(1'b1, 1'b1);
    bus(OFS_CTRL, 32'h1, 1'b1);
    cyc(3);
    pairs(1'b0, 1'b0);
    up_u.close_pair(3);
    cyc(4);
    pairs(1'b1, 1'b1);
    @(posedge clk_i);
    pf_free_a_i <= 1'b0;
    cyc(2);
    pairs(1'b0, 1'b0);
    @(posedge clk_i);
    pf_free_a_i <= 1'b1;
    cyc(3);
    up_u.open_pair();
    cyc(2);
    pairs(1'b0, 1'b0);
    // Simultaneity fault with its interrupt
    bus(OFS_STATUS, 32'hF, 1'b1);
    bus(OFS_MASK, 32'h2, 1'b1);
    up_u.close_one();
    cyc(WIN + 8);
    flag("link_fault_o", 1'b1, link_fault_o);
    flag("irq_o", 1'b1, irq_o);
    rd_reg(OFS_STATUS, 32'h2);
    up_u.close_pair(0);
    cyc(4);
    pairs(1'b0, 1'b0);
    bus(OFS_STATUS, 32'h2, 1'b1);
    cyc(2);
    flag("irq_o", 1'b0, irq_o);
    up_u.open_pair();
    bus(OFS_CTRL, 32'h3, 1'b1);
    up_u.close_pair(2);
    cyc(4);
    pairs(1'b1, 1'b1);
    flag("link_fault_o", 1'b0, link_fault_o);
    up_u.open_pair();
    cyc(4);
    flag("irq_o", 1'b0, irq_o);
    rd_reg(OFS_STATUS, 32'hD);
    bus(OFS_MASK, 32'h1, 1'b1);
    cyc(2);
    flag("irq_o", 1'b1, irq_o);
    bus(OFS_STATUS, 32'hF, 1'b1);
    cyc(2);
    flag("irq_o", 1'b0, irq_o);
    // Two protective functions
    bus(OFS_CTRL, 32'h5, 1'b1);
    cyc(3);
    pairs(1'b0, 1'b1);
    up_u.close_pair(1);
    cyc(4);
    @(posedge clk_i);
    pf_free_b_i <= 1'b0;
    cyc(3);
    pairs(1'b1, 1'b0);
    @(posedge clk_i);
    pf_free_b_i <= 1'b1;
    bus(OFS_CTRL, 32'hD, 1'b1);
    up_u.open_pair();
    cyc(3);
    pairs(1'b1, 1'b0);
    // Delayed second pair behind linkage
    up_u.close_pair(0);
    bus(OFS_DELAY, 32'h8, 1'b1);
    bus(OFS_CTRL, 32'h11, 1'b1);
    cyc(4);
    pairs(1'b1, 1'b1);
    up_u.open_pair();
    cyc(3);
    pairs(1'b0, 1'b1);
    cyc(12);
    pairs(1'b0, 1'b0);
    // Indication routing
    bus(OFS_CTRL, 32'h0, 1'b1);
    for (int i = 0; i < 6; i++) begin
      map = (i == 0) ? 12'h68A : (i == 1) ? 12'hFAC : 12'($random(seed));
      bus(OFS_SIGMAP, {20'h0, map}, 1'b1);
      rd_reg(OFS_SIGMAP, {20'h0, map});
      @(posedge clk_i);
      sig_i <= lmon_sig_t'(6'($random(seed)));
      pf_free_a_i <= 1'($random(seed));
      pf_free_b_i <= 1'($random(seed));
      cyc(3);
      @(negedge clk_i);
      src = {sig_i.diag, sig_i.warn, sig_i.err, sig_i.dev_func, sig_i.fp_change, sig_i.wf_viol,
        !pf_free_b_i, !pf_free_a_i};
      for (int k = 0; k < IND_N; k++) begin
        exp_ind[k] = src[map[3*k +: 3]];
      end
      chk("ind_o", {28'h0, exp_ind}, {28'h0, ind_o});
    end
    // Clock enable low freezes the output pairs
    @(posedge clk_i);
    pf_free_a_i <= 1'b1;
    cyc(3);
    pairs(1'b1, 1'b1);
    @(posedge clk_i);
    ce_i <= 1'b0;
    pf_free_a_i <= 1'b0;
    cyc(3);
    pairs(1'b1, 1'b1);
    @(posedge clk_i);
    ce_i <= 1'b1;
    cyc(2);
    pairs(1'b0, 1'b0);
    cyc(2);
    wrap_up();
  end
endmodule
